// file: verilog/sto_pkg.sv
// constants, types and register map of the safe-torque-off monitor
package sto_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_HZ = 40_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int DISCREPANCY_MS = 3000;
	localparam int DUAL_WINDOW_MS = 1000;
	localparam int RAMP_TICK_US = 1;
	localparam int RAMP_TICK_CYCLES = (RAMP_TICK_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int CNT_W = 28;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] ADDR_SETPOINT = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] ADDR_RAMP_STEP = 8'h18;

	// ==========================================================
	// fields and reset values
	localparam int SPEED_W = 16;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_STOP_BIT = 1;
	localparam int IRQ_W = 3;
	localparam int IRQ_TRIP_BIT = 0;
	localparam int IRQ_FAULT_BIT = 1;
	localparam int IRQ_STATUS_BIT = 2;
	localparam logic [SPEED_W-1:0] SETPOINT_RST = 16'h0000;
	localparam logic [SPEED_W-1:0] RAMP_STEP_RST = 16'h0001;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RST = 3'h0;
	localparam logic [1:0] SYNC_RST = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RUN = 3'b001,
		ST_DECEL = 3'b010,
		ST_TRIP = 3'b011,
		ST_FAULT = 3'b100
	} drive_state_e;

	// state register layout, bit 0 upward: chan_a, chan_b, trip, fault, status, power_en
	typedef struct packed {
		logic power_en;
		logic status;
		logic fault;
		logic trip;
		logic chan_b;
		logic chan_a;
	} sto_flags_s;

endpackage

// file: verilog/sto_input_sync.sv
// two-flop synchroniser for the two request pins
`timescale 1ns/1ps
`default_nettype none
module sto_input_sync
	import sto_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [1:0] i_async,
	output logic [1:0] o_sync
);

	logic [1:0] meta_reg;
	logic [1:0] sync_reg;

	// ==========================================================
	// reset to "requests active" so a healthy power-up shows no trip
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			meta_reg <= SYNC_RST;
			sync_reg <= SYNC_RST;
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;

endmodule
`default_nettype wire

// file: verilog/sto_interval_timer.sv
// saturating cycle counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module sto_interval_timer
	import sto_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_clear,
	input wire logic i_run,
	output logic [CNT_W-1:0] o_count
);

	logic [CNT_W-1:0] count_reg;

	// ==========================================================
	// saturates so a stuck condition never wraps back to a small count
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n || i_clear)
			count_reg <= '0;
		else if (i_run && count_reg != {CNT_W{1'b1}})
			count_reg <= count_reg + 1'b1;
	end

	assign o_count = count_reg;

endmodule
`default_nettype wire

// file: verilog/sto_monitor.sv
// safe-torque-off monitor with drive sequencing and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - either request withdrawn: cut motor power at once and flag trip
// - power removal completes well within 10 ms of the withdrawal
// - single loss up to 1 s trips, status off, no fault
// - after brief loss, both active plus restart clears trip, resumes setpoint
// - single loss over 3 s latches fault; start refused, trip kept
// - fault keeps status off; only power cycle clears it
// - party withdraws both within 1 s; status output then turns on
// - both withdrawn: run commands ignored, trip and status kept
// - both restored after dual withdrawal: status off immediately
// - after restore trip stays until restart, then runs at setpoint
// - power-up with both active: no trip, status off
// - normal running follows setpoint with status off
// - ordinary stop ramps speed down under control, status off
// - status on only when both channels withdrawn and found healthy
module sto_monitor
	import sto_pkg::*;
#(
	parameter int unsigned DISCREPANCY_CYCLES = CLK_KHZ * DISCREPANCY_MS,
	parameter int unsigned DUAL_WINDOW_CYCLES = CLK_KHZ * DUAL_WINDOW_MS
)
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_channel_a_request_input,
	input wire logic i_channel_b_request_input,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_sto_status_output,
	output logic o_motor_power_enable,
	output logic [SPEED_W-1:0] o_speed_command,
	output logic o_sto_trip,
	output logic o_fault_latched,
	output logic o_irq
);

	localparam logic [CNT_W-1:0] DISC_LIMIT = CNT_W'(DISCREPANCY_CYCLES);
	localparam logic [CNT_W-1:0] WINDOW_LIMIT = CNT_W'(DUAL_WINDOW_CYCLES);
	localparam logic [CNT_W-1:0] RAMP_LIMIT = CNT_W'(RAMP_TICK_CYCLES - 1);

	// ==========================================================
	// declarations
	logic [1:0] chan_sync;
	logic chan_a;
	logic chan_b;
	logic both_on;
	logic both_off;
	logic single_off;
	logic [CNT_W-1:0] disc_count;
	logic [CNT_W-1:0] ramp_count;
	logic ramp_tick;
	logic disc_expired;
	logic dual_entry;
	logic dual_ok_now;
	logic both_off_d_reg;
	logic dual_ok_reg;
	logic fault_reg;
	logic status_reg;
	logic trip_reg;
	logic trip_next;
	logic power_en_reg;
	drive_state_e state_reg;
	drive_state_e state_next;
	logic [SPEED_W-1:0] speed_reg;
	logic [SPEED_W-1:0] speed_next;
	logic [SPEED_W-1:0] setpoint_reg;
	logic [SPEED_W-1:0] ramp_step_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_enable_reg;
	logic [IRQ_W-1:0] irq_event;
	logic [IRQ_W-1:0] irq_clear;
	logic ahb_take;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [31:0] rdata_reg;
	logic wr_setpoint;
	logic wr_command;
	logic wr_irq_clear;
	logic wr_irq_enable;
	logic wr_ramp_step;
	logic cmd_start;
	logic cmd_stop;
	sto_flags_s flags;

	// ==========================================================
	// word offset of a bus address; bits outside the map give an unmapped hit
	function automatic logic [7:0] word_offset(input logic [31:0] addr);
		word_offset = (addr[31:8] == 24'h000000) ? {addr[7:2], 2'b00} : 8'hFF;
	endfunction

	// ==========================================================
	// request inputs
	sto_input_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_async({i_channel_b_request_input, i_channel_a_request_input}),
		.o_sync(chan_sync)
	);

	assign chan_a = chan_sync[0];
	assign chan_b = chan_sync[1];
	assign both_on = chan_a & chan_b;
	assign both_off = ~chan_a & ~chan_b;
	assign single_off = chan_a ^ chan_b;

	// ==========================================================
	// discrepancy timing from the first channel's withdrawal
	sto_interval_timer u_disc_timer (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clear(~single_off),
		.i_run(single_off),
		.o_count(disc_count)
	);

	// one limit sets the fault, longer than the brief-loss allowance
	assign disc_expired = single_off && (disc_count >= DISC_LIMIT);
	// count still holds the gap in the cycle both are first seen off
	assign dual_entry = both_off & ~both_off_d_reg;
	assign dual_ok_now = dual_entry ? (disc_count <= WINDOW_LIMIT) : dual_ok_reg;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			both_off_d_reg <= 1'b0;
			dual_ok_reg <= 1'b0;
		end
		else
		begin
			both_off_d_reg <= both_off;
			dual_ok_reg <= both_off & dual_ok_now;
		end
	end

	// ==========================================================
	// fault latch: only reset, i.e. a power cycle, clears it
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			fault_reg <= 1'b0;
		else if (disc_expired)
			fault_reg <= 1'b1;
	end

	// ==========================================================
	// status output
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			status_reg <= 1'b0;
		else
			status_reg <= both_off & dual_ok_now & ~fault_reg & ~disc_expired;
	end

	// ==========================================================
	// drive sequencing
	always_comb
	begin
		state_next = state_reg;
		if (fault_reg || disc_expired)
			state_next = ST_FAULT;
		else if (!both_on)
			state_next = ST_TRIP;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (cmd_start && !cmd_stop)
						state_next = ST_RUN;
				ST_RUN:
					if (cmd_stop)
						state_next = ST_DECEL;
				ST_DECEL:
				begin
					if (cmd_start && !cmd_stop)
						state_next = ST_RUN;
					else if (speed_reg == '0)
						state_next = ST_IDLE;
				end
				ST_TRIP:
					if (cmd_start && !cmd_stop)
						state_next = ST_RUN;
				// covers the fault state and any illegal code
				default: state_next = ST_FAULT;
			endcase
		end
	end

	assign trip_next = (state_next == ST_TRIP) || (state_next == ST_FAULT);

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_IDLE;
			trip_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			trip_reg <= trip_next;
		end
	end

	// ==========================================================
	// motor power and speed
	// power drops one edge after the synced pin, far inside the response limit
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			power_en_reg <= 1'b0;
		else
			power_en_reg <= (state_next == ST_RUN) || (state_next == ST_DECEL);
	end

	sto_interval_timer u_ramp_timer (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.i_clear(ramp_tick),
		.i_run(1'b1),
		.o_count(ramp_count)
	);

	assign ramp_tick = (ramp_count >= RAMP_LIMIT);

	always_comb
	begin
		unique case (state_next)
			ST_RUN: speed_next = setpoint_reg;
			ST_DECEL:
			begin
				if (!ramp_tick)
					speed_next = speed_reg;
				else if (speed_reg > ramp_step_reg)
					speed_next = speed_reg - ramp_step_reg;
				else
					speed_next = '0;
			end
			default: speed_next = '0;
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			speed_reg <= '0;
		else
			speed_reg <= speed_next;
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY
	assign ahb_take = i_hsel & i_htrans[1] & i_hready;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'hFF;
		end
		else
		begin
			wr_pend_reg <= ahb_take & i_hwrite & (i_hsize == 3'b010);
			wr_addr_reg <= word_offset(i_haddr);
		end
	end

	assign wr_setpoint = wr_pend_reg && (wr_addr_reg == ADDR_SETPOINT);
	assign wr_command = wr_pend_reg && (wr_addr_reg == ADDR_COMMAND);
	assign wr_irq_clear = wr_pend_reg && (wr_addr_reg == ADDR_IRQ_CLEAR);
	assign wr_irq_enable = wr_pend_reg && (wr_addr_reg == ADDR_IRQ_ENABLE);
	assign wr_ramp_step = wr_pend_reg && (wr_addr_reg == ADDR_RAMP_STEP);
	// a start and stop written together act as stop
	assign cmd_start = wr_command & i_hwdata[CMD_START_BIT];
	assign cmd_stop = wr_command & i_hwdata[CMD_STOP_BIT];

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			setpoint_reg <= SETPOINT_RST;
			ramp_step_reg <= RAMP_STEP_RST;
			irq_enable_reg <= IRQ_ENABLE_RST;
		end
		else
		begin
			if (wr_setpoint)
				setpoint_reg <= i_hwdata[SPEED_W-1:0];
			if (wr_ramp_step)
				ramp_step_reg <= i_hwdata[SPEED_W-1:0];
			if (wr_irq_enable)
				irq_enable_reg <= i_hwdata[IRQ_W-1:0];
		end
	end

	assign flags = {power_en_reg, status_reg, fault_reg, trip_reg, chan_b, chan_a};

	// read data sampled at the address phase, shown in the data phase
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			rdata_reg <= 32'h00000000;
		else if (ahb_take && !i_hwrite)
		begin
			unique case (word_offset(i_haddr))
				ADDR_SETPOINT: rdata_reg <= {16'h0000, setpoint_reg};
				ADDR_STATE: rdata_reg <= {speed_reg, 5'h00, state_reg, 2'b00, flags};
				ADDR_IRQ_STATUS: rdata_reg <= {29'h00000000, irq_status_reg};
				ADDR_IRQ_ENABLE: rdata_reg <= {29'h00000000, irq_enable_reg};
				ADDR_RAMP_STEP: rdata_reg <= {16'h0000, ramp_step_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
	end

	assign o_hrdata = rdata_reg;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// ==========================================================
	// interrupts: a new event wins over a clear in the same cycle
	assign irq_event[IRQ_TRIP_BIT] = trip_next & ~trip_reg;
	assign irq_event[IRQ_FAULT_BIT] = disc_expired & ~fault_reg;
	assign irq_event[IRQ_STATUS_BIT] = both_off & dual_ok_now & ~fault_reg & ~disc_expired & ~status_reg;
	assign irq_clear = wr_irq_clear ? i_hwdata[IRQ_W-1:0] : '0;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
			irq_status_reg <= '0;
		else
			irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
	end

	assign o_irq = |(irq_status_reg & irq_enable_reg);

	// ==========================================================
	// outputs
	assign o_sto_status_output = status_reg;
	assign o_motor_power_enable = power_en_reg;
	assign o_speed_command = speed_reg;
	assign o_sto_trip = trip_reg;
	assign o_fault_latched = fault_reg;

endmodule
`default_nettype wire

// file: tb/sto_monitor_assertions.sv
// concurrent checks on the safe-torque-off monitor ports
`timescale 1ns/1ps
`default_nettype none
module sto_monitor_chk
	import sto_pkg::*;
#(
	parameter int unsigned DISCREPANCY_CYCLES = 300,
	parameter int unsigned DUAL_WINDOW_CYCLES = 100
)
(
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_channel_a_request_input,
	input wire logic i_channel_b_request_input,
	input wire logic o_sto_status_output,
	input wire logic o_motor_power_enable,
	input wire logic [SPEED_W-1:0] o_speed_command,
	input wire logic o_sto_trip,
	input wire logic o_fault_latched
);
	// ==========================================
	// assertions
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// pin plus two sync flops plus state flop: five samples cover it
	power_cut_a: assert property ((!i_channel_a_request_input || !i_channel_b_request_input) [*5]
		|-> !o_motor_power_enable && o_speed_command == 16'h0000) else $error("power not cut");
	trip_on_loss_a: assert property ($fell(i_channel_a_request_input)
		|-> ##[1:4] (o_sto_trip && !o_motor_power_enable)) else $error("no trip after loss");
	status_healthy_a: assert property (o_sto_status_output
		|-> o_sto_trip && !o_fault_latched && !o_motor_power_enable) else $error("status while unhealthy");
	fault_sticky_a: assert property (o_fault_latched
		|=> o_fault_latched && o_sto_trip && !o_sto_status_output) else $error("fault latch lost");
	clean_boot_a: assert property ($rose(i_reset_n) && i_channel_a_request_input && i_channel_b_request_input
		|-> (!o_sto_trip && !o_sto_status_output) [*3]) else $error("error after power-up");
	ramp_rest_a: assert property ($fell(o_motor_power_enable) && !o_sto_trip
		|-> $past(o_speed_command) == 16'h0000) else $error("stop did not ramp to rest");
	status_release_a: assert property ($rose(i_channel_a_request_input)
		|-> ##[1:4] !o_sto_status_output) else $error("status kept after restore");
	trip_hold_a: assert property (o_sto_trip && !(i_channel_a_request_input && i_channel_b_request_input)
		|=> o_sto_trip) else $error("trip cleared while withdrawn");
	cover property ($rose(o_sto_status_output));
	cover property ($rose(o_fault_latched));
	cover property ($fell(o_motor_power_enable) && !o_sto_trip);
endmodule

bind sto_monitor sto_monitor_chk #(.DISCREPANCY_CYCLES(DISCREPANCY_CYCLES), .DUAL_WINDOW_CYCLES(DUAL_WINDOW_CYCLES))
	u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.i_channel_a_request_input(i_channel_a_request_input), .i_channel_b_request_input(i_channel_b_request_input),
	.o_sto_status_output(o_sto_status_output), .o_motor_power_enable(o_motor_power_enable),
	.o_speed_command(o_speed_command), .o_sto_trip(o_sto_trip), .o_fault_latched(o_fault_latched));
`default_nettype wire

// file: tb/sto_contacts.sv
// model of the safety control unit contacts feeding both request pins
`timescale 1ns/1ps
`default_nettype none
module sto_contacts
(
	input wire logic i_clk_sys,
	input wire logic i_open_a,
	input wire logic i_open_b,
	output logic o_chan_a = 1'b1,
	output logic o_chan_b = 1'b1
);
	// ==========================================
	// contacts
	// closed contact drives high; an open one pulls the pin low, never left floating
	always @(posedge i_clk_sys)
	begin
		o_chan_a <= !i_open_a;
		o_chan_b <= !i_open_b;
	end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench of the safe-torque-off monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sto_pkg::*;
	// ==========================================
	// signals and instances
	localparam int DISC = 300;
	logic i_clk_sys = 1'b0;
	logic i_reset_n = 1'b0;
	logic open_a = 1'b0;
	logic open_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] rdat;
	wire logic pin_a;
	wire logic pin_b;
	wire logic [31:0] hrdata;
	wire logic hready;
	wire logic hresp;
	wire logic status;
	wire logic power;
	wire logic trip;
	wire logic fault;
	wire logic irq;
	wire logic [SPEED_W-1:0] speed;
	wire logic [19:0] outs = {status, power, trip, fault, speed};
	int error_cnt = 0;
	int samples_checked = 0;

	always #12.5 i_clk_sys = ~i_clk_sys;

	sto_contacts u_contacts (.i_clk_sys(i_clk_sys), .i_open_a(open_a), .i_open_b(open_b),
		.o_chan_a(pin_a), .o_chan_b(pin_b));
	// short counts keep the discrepancy and dual window runs brief
	sto_monitor #(.DISCREPANCY_CYCLES(DISC), .DUAL_WINDOW_CYCLES(100)) dut (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_channel_a_request_input(pin_a), .i_channel_b_request_input(pin_b),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.o_sto_status_output(status), .o_motor_power_enable(power), .o_speed_command(speed),
		.o_sto_trip(trip), .o_fault_latched(fault), .o_irq(irq));

	// ==========================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask

	// waits as long as the slave stalls; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge i_clk_sys);
		while (hready !== 1'b1)
			@(posedge i_clk_sys);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge i_clk_sys);
		while (hready !== 1'b1)
			@(posedge i_clk_sys);
		rdat = hrdata;
	endtask

	// ==========================================
	// scenarios
	task automatic t_boot;
		wt(2);
		chk("outs", {12'h000, outs}, 32'h00000000);
		chk("hresp", {31'h0, hresp}, 32'h00000000);
		bus(1'b0, ADDR_STATE, 32'h0);
		chk("state", rdat, 32'h00000003);
		bus(1'b0, ADDR_RAMP_STEP, 32'h0);
		chk("ramp", rdat, 32'h00000001);
		bus(1'b1, 8'h1C, 32'hFFFFFFFF);
		bus(1'b0, 8'h1C, 32'h0);
		chk("unmapped", rdat, 32'h00000000);
	endtask

	task automatic t_run;
		bus(1'b1, ADDR_SETPOINT, 32'h00001234);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h00000007);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(2);
		chk("run", {12'h000, outs}, 32'h00041234);
	endtask

	task automatic t_single(input logic b);
		open_a <= !b;
		open_b <= b;
		wt(6);
		chk("lost", {12'h000, outs}, 32'h00020000);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(70);
		chk("brief", {4'h0, outs, 7'h00, irq}, 32'h02000000);
		open_a <= 1'b0;
		open_b <= 1'b0;
		wt(4);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(2);
		chk("restart", {12'h000, outs}, 32'h00041234);
		bus(1'b1, ADDR_IRQ_CLEAR, 32'h00000007);
		bus(1'b1, ADDR_IRQ_ENABLE, 32'h00000007);
		wt(1);
		chk("irq clear", {31'h0, irq}, 32'h0);
	endtask

	task automatic t_fault(input logic b);
		open_a <= !b;
		open_b <= b;
		wt(DISC + 20);
		chk("fault", {12'h000, outs}, 32'h00030000);
		open_a <= 1'b0;
		open_b <= 1'b0;
		wt(4);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(2);
		chk("refused", {12'h000, outs}, 32'h00030000);
		i_reset_n <= 1'b0;
		wt(12);
		i_reset_n <= 1'b1;
		wt(2);
		chk("cycled", {12'h000, outs}, 32'h00000000);
		t_run();
	endtask

	task automatic t_dual;
		open_a <= 1'b1;
		// slow partner: second contact opens late, still inside the window
		wt(90);
		open_b <= 1'b1;
		wt(4);
		chk("dual", {12'h000, outs}, 32'h000A0000);
		repeat (4) bus(1'b1, ADDR_COMMAND, 32'h00000001);
		chk("held", {12'h000, outs}, 32'h000A0000);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk("irq status", rdat, 32'h00000005);
		open_a <= 1'b0;
		open_b <= 1'b0;
		wt(4);
		chk("restored", {12'h000, outs}, 32'h00020000);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(2);
		chk("resume", {12'h000, outs}, 32'h00041234);
	endtask

	task automatic t_late;
		open_b <= 1'b1;
		// second contact opens past the window: trip, but status stays off
		wt(150);
		open_a <= 1'b1;
		wt(4);
		chk("late", {12'h000, outs}, 32'h00020000);
		open_a <= 1'b0;
		open_b <= 1'b0;
		wt(4);
		bus(1'b1, ADDR_COMMAND, 32'h00000001);
		wt(2);
		chk("late resume", {12'h000, outs}, 32'h00041234);
	endtask

	task automatic t_stop;
		int n;
		n = 0;
		bus(1'b1, ADDR_RAMP_STEP, 32'h00000100);
		bus(1'b1, ADDR_COMMAND, 32'h00000002);
		wt(50);
		chk("ramping", {28'h0, outs[19:16]}, 32'h00000004);
		while (power === 1'b1 && n++ < 2000)
			wt(1);
		chk("rest", {12'h000, outs}, 32'h00000000);
	endtask

	// ==========================================
	// run control
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		wt(12);
		i_reset_n <= 1'b1;
		t_boot();
		t_run();
		t_single(1'b0);
		t_single(1'b1);
		t_fault(1'b0);
		t_fault(1'b1);
		t_dual();
		t_late();
		t_stop();
		stop_test();
	end

	// whole sequence needs about 2000 cycles
	initial
	begin
		#250000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire
